// [logic/codec_ctrl_port.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// - Answer on the two-wire bus only at seven-bit address 0011010.
// - Data line holds steady while clock is high; changes only with clock low.
// - START is data falling with clock high; STOP is data rising with clock high.
// - A repeated START restarts decoding exactly like a first START.
// - Bus is busy from START until STOP, idle after STOP.
// - Every byte is eight bits, most significant bit first.
// - Ninth clock carries acknowledge; transmitter releases, receiver pulls low.
// - Once addressed, acknowledge address, index and every data byte received.
// - Direction bit zero means write, one means read.
// - Write is address byte, register index byte, then data byte.
// - Written value takes effect at clock rise of the final slave acknowledge.
// - Strap high selects three-wire mode; test/select pin becomes chip select.
// - Three-wire transfers are accepted only while chip select is low.
// - In three-wire mode only, second general pin drives serial read data when its field selects it.
// - Address top bit set requests a read; upper locations mirror registers.
module codec_ctrl_port #(
   parameter int RegCount = codec_ctrl_pkg::REG_COUNT
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic serialClkPin,
   input wire logic serialDataIn,
   output logic serialDataOut,
   output logic serialDataOeN,
   input wire logic ifaceSelStrap,
   input wire logic chipSelectN,
   output logic generalPinTwoOut,
   output logic generalPinTwoOeN,
   output logic regWritePulse,
   output logic [7:0] regWriteIndex,
   output logic [7:0] regWriteValue,
   output logic busBusy,
   output logic threeWireMode
);
   localparam int AW = (RegCount > 1) ? $clog2(RegCount) : 1;

   if (RegCount < 1 || RegCount > 128) begin : g_check
      $error("RegCount must lie between 1 and 128");
   end

   // Index within the implemented register set
   function automatic logic inRange(input logic [7:0] idx);
      return int'(idx) < RegCount;
   endfunction

   codec_ctrl_pkg::i2c_state_t state_q;
   logic sclS, sdaS, csNS, strapS;
   logic sclP_q, sdaP_q, csNP_q;
   logic spiMode_q;
   logic busy_q;
   logic [3:0] bitCnt_q;
   logic [7:0] rxShift_q;
   logic [7:0] txShift_q;
   logic sdaLow_q;
   logic ackSeen_q;
   logic [7:0] index_q;
   logic [4:0] spiCnt_q;
   logic [7:0] spiShift_q;
   logic spiRead_q;
   logic [7:0] spiTx_q;
   logic pinDrive_q;
   logic [7:0] rdData;
   logic [7:0] tapData;
   logic [7:0] readByte;
   logic [2:0] pinFunc;
   logic sclRise, sclFall, startCond, stopCond;
   logic i2cIdxLoad, i2cWrAck, i2cCommit, i2cRdNext;
   logic spiAddrDone, spiDeselect, spiCommit;
   logic wrEn;
   logic [7:0] wrVal;

   // Pins come from the master's domain; the bus clock is only sampled here
   sync2 #(
      .W(4),
      .RESET_VAL(4'hF)
   ) u_pin_sync (
      .clk(clk),
      .srst(srst),
      .d({serialClkPin, serialDataIn, chipSelectN, ifaceSelStrap}),
      .q({sclS, sdaS, csNS, strapS})
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
         csNP_q <= 1'b1;
      end else begin
         sclP_q <= sclS;
         sdaP_q <= sdaS;
         csNP_q <= csNS;
      end
   end

   // Strap is caught while reset is held, so the mode never changes mid-run
   always_ff @(posedge clk) begin
      if (srst) begin
         spiMode_q <= strapS;
      end
   end

   assign sclRise = sclS & ~sclP_q;
   assign sclFall = ~sclS & sclP_q;
   assign startCond = ~spiMode_q & sclS & sclP_q & sdaP_q & ~sdaS;
   assign stopCond = ~spiMode_q & sclS & sclP_q & ~sdaP_q & sdaS;

   always_ff @(posedge clk) begin
      if (srst || spiMode_q || stopCond) begin
         busy_q <= 1'b0;
      end else if (startCond) begin
         busy_q <= 1'b1;
      end
   end

   assign readByte = inRange(index_q) ? rdData : codec_ctrl_pkg::REG_RESET;

   // Two-wire slave; every drive change happens after a sampled clock fall
   always_ff @(posedge clk) begin
      if (srst || spiMode_q || stopCond) begin
         state_q <= codec_ctrl_pkg::ST_IDLE;
         bitCnt_q <= '0;
         rxShift_q <= '0;
         txShift_q <= '0;
         sdaLow_q <= 1'b0;
         ackSeen_q <= 1'b0;
      end else if (startCond) begin
         state_q <= codec_ctrl_pkg::ST_ADDR;
         bitCnt_q <= '0;
         sdaLow_q <= 1'b0;
      end else begin
         unique case (state_q)
            codec_ctrl_pkg::ST_IDLE, codec_ctrl_pkg::ST_IGNORE: begin
               sdaLow_q <= 1'b0;
            end
            codec_ctrl_pkg::ST_ADDR, codec_ctrl_pkg::ST_INDEX,
            codec_ctrl_pkg::ST_WDATA: begin
               if (sclRise && bitCnt_q < codec_ctrl_pkg::BYTE_LEN) begin
                  rxShift_q <= {rxShift_q[6:0], sdaS};
                  bitCnt_q <= bitCnt_q + 4'h1;
               end else if (sclFall && bitCnt_q == codec_ctrl_pkg::BYTE_LEN) begin
                  bitCnt_q <= '0;
                  sdaLow_q <= 1'b1;
                  if (state_q == codec_ctrl_pkg::ST_ADDR) begin
                     if (rxShift_q[7:1] == codec_ctrl_pkg::I2C_SLAVE_ADDR) begin
                        state_q <= codec_ctrl_pkg::ST_ADDR_ACK;
                     end else begin
                        state_q <= codec_ctrl_pkg::ST_IGNORE;
                        sdaLow_q <= 1'b0;
                     end
                  end else if (state_q == codec_ctrl_pkg::ST_INDEX) begin
                     state_q <= codec_ctrl_pkg::ST_INDEX_ACK;
                  end else begin
                     state_q <= codec_ctrl_pkg::ST_WDATA_ACK;
                  end
               end
            end
            codec_ctrl_pkg::ST_ADDR_ACK: begin
               if (sclFall) begin
                  if (rxShift_q[0]) begin
                     state_q <= codec_ctrl_pkg::ST_RDATA;
                     txShift_q <= readByte;
                     sdaLow_q <= ~readByte[7];
                  end else begin
                     state_q <= codec_ctrl_pkg::ST_INDEX;
                     sdaLow_q <= 1'b0;
                  end
               end
            end
            codec_ctrl_pkg::ST_INDEX_ACK, codec_ctrl_pkg::ST_WDATA_ACK: begin
               if (sclFall) begin
                  state_q <= codec_ctrl_pkg::ST_WDATA;
                  sdaLow_q <= 1'b0;
               end
            end
            codec_ctrl_pkg::ST_RDATA: begin
               if (sclFall) begin
                  if (bitCnt_q == codec_ctrl_pkg::BYTE_LAST) begin
                     state_q <= codec_ctrl_pkg::ST_RDATA_ACK;
                     bitCnt_q <= '0;
                     sdaLow_q <= 1'b0;
                  end else begin
                     txShift_q <= {txShift_q[6:0], 1'b0};
                     sdaLow_q <= ~txShift_q[6];
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
               end
            end
            codec_ctrl_pkg::ST_RDATA_ACK: begin
               if (sclRise) begin
                  ackSeen_q <= ~sdaS;
               end else if (sclFall) begin
                  if (ackSeen_q) begin
                     state_q <= codec_ctrl_pkg::ST_RDATA;
                     txShift_q <= readByte;
                     sdaLow_q <= ~readByte[7];
                  end else begin
                     state_q <= codec_ctrl_pkg::ST_IGNORE;
                  end
               end
            end
            default: begin
               state_q <= codec_ctrl_pkg::ST_IGNORE;
               sdaLow_q <= 1'b0;
            end
         endcase
      end
   end

   assign i2cIdxLoad = (state_q == codec_ctrl_pkg::ST_INDEX) & sclFall
      & (bitCnt_q == codec_ctrl_pkg::BYTE_LEN);
   assign i2cWrAck = (state_q == codec_ctrl_pkg::ST_WDATA_ACK) & sclRise;
   assign i2cCommit = i2cWrAck & inRange(index_q);
   assign i2cRdNext = (state_q == codec_ctrl_pkg::ST_RDATA_ACK) & sclRise & ~sdaS;

   // Three-wire slave; chip select high holds the frame logic in reset
   always_ff @(posedge clk) begin
      if (srst || !spiMode_q || csNS) begin
         spiCnt_q <= '0;
         spiRead_q <= 1'b0;
      end else if (sclRise && spiCnt_q < codec_ctrl_pkg::SPI_FRAME_LEN) begin
         spiCnt_q <= spiCnt_q + 5'h01;
         if (spiCnt_q == codec_ctrl_pkg::SPI_ADDR_LAST) begin
            spiRead_q <= spiShift_q[codec_ctrl_pkg::SPI_READ_BIT - 1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         spiShift_q <= '0;
      end else if (spiMode_q && !csNS && sclRise
                   && spiCnt_q < codec_ctrl_pkg::SPI_FRAME_LEN) begin
         spiShift_q <= {spiShift_q[6:0], sdaS};
      end
   end

   // Read data leaves on falling edges so the master can sample on the rise
   always_ff @(posedge clk) begin
      if (srst) begin
         spiTx_q <= '0;
      end else if (spiMode_q && !csNS && sclFall) begin
         if (spiCnt_q == codec_ctrl_pkg::SPI_ADDR_LEN) begin
            spiTx_q <= spiRead_q ? readByte : codec_ctrl_pkg::REG_RESET;
         end else begin
            spiTx_q <= {spiTx_q[6:0], 1'b0};
         end
      end
   end

   assign spiAddrDone = spiMode_q & ~csNS & sclRise
      & (spiCnt_q == codec_ctrl_pkg::SPI_ADDR_LAST);
   assign spiDeselect = spiMode_q & csNS & ~csNP_q;
   // Mirrored upper locations are read-only, so a write there is dropped
   assign spiCommit = spiDeselect & (spiCnt_q == codec_ctrl_pkg::SPI_FRAME_LEN)
      & ~spiRead_q & inRange(index_q);

   // Index is shared: the read path always looks at it, whichever mode set it
   always_ff @(posedge clk) begin
      if (srst) begin
         index_q <= '0;
      end else if (i2cIdxLoad) begin
         index_q <= rxShift_q;
      end else if (spiAddrDone) begin
         index_q <= {1'b0, spiShift_q[5:0], sdaS};
      end else if (i2cWrAck || i2cRdNext) begin
         index_q <= index_q + 8'h01;
      end
   end

   assign wrEn = i2cCommit | spiCommit;
   assign wrVal = spiMode_q ? spiShift_q : rxShift_q;

   reg_store #(
      .Depth(RegCount),
      .AddrW(AW),
      .TapAddr(int'(codec_ctrl_pkg::PIN_FUNC_REG))
   ) u_regs (
      .clk(clk),
      .srst(srst),
      .wrEn(wrEn),
      .wrAddr(index_q[AW-1:0]),
      .wrData(wrVal),
      .rdAddr(index_q[AW-1:0]),
      .rdData(rdData),
      .tapData(tapData)
   );

   assign pinFunc = tapData[codec_ctrl_pkg::PIN_FUNC_LSB +: codec_ctrl_pkg::PIN_FUNC_W];

   always_ff @(posedge clk) begin
      if (srst) begin
         pinDrive_q <= 1'b0;
      end else begin
         pinDrive_q <= spiMode_q && pinFunc == codec_ctrl_pkg::PIN_FUNC_SERIAL_OUT;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         regWritePulse <= 1'b0;
         regWriteIndex <= '0;
         regWriteValue <= '0;
      end else begin
         regWritePulse <= wrEn;
         regWriteIndex <= index_q;
         regWriteValue <= wrVal;
      end
   end

   // Open-drain data line: only ever pulls low
   assign serialDataOut = 1'b0;
   assign serialDataOeN = ~sdaLow_q;
   assign generalPinTwoOut = spiTx_q[7];
   assign generalPinTwoOeN = ~pinDrive_q;
   assign busBusy = busy_q;
   assign threeWireMode = spiMode_q;
endmodule
`default_nettype wire

// [pkg/codec_ctrl_pkg.sv]
package codec_ctrl_pkg;

   // Fixed two-wire slave address, binary 0011010
   localparam logic [6:0] I2C_SLAVE_ADDR = 7'h1A;

   // Register set: locations 0x00 to 0x25, all cleared at reset
   localparam int REG_COUNT = 38;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Serial framing
   localparam logic [3:0] BYTE_LEN = 4'h8;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [4:0] SPI_ADDR_LEN = 5'h08;
   localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
   localparam logic [4:0] SPI_FRAME_LEN = 5'h10;
   localparam int SPI_READ_BIT = 7;

   // Pin-function field of the second general-purpose pin
   localparam logic [7:0] PIN_FUNC_REG = 8'h1A;
   localparam int PIN_FUNC_LSB = 3;
   localparam int PIN_FUNC_W = 3;
   localparam logic [2:0] PIN_FUNC_SERIAL_OUT = 3'h1;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ADDR_ACK  = 4'h2,
      ST_INDEX     = 4'h3,
      ST_INDEX_ACK = 4'h4,
      ST_WDATA     = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA     = 4'h7,
      ST_RDATA_ACK = 4'h8,
      ST_IGNORE    = 4'h9
   } i2c_state_t;

endpackage

// [logic/sync2.sv]
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_check
      $error("sync2 needs at least one bit");
   end

   // First stage is read by the second stage only
   // No reset on purpose: the strap must reach the mode latch while reset is held
   always_ff @(posedge clk) begin
      meta_q <= d;
      q <= meta_q;
   end
endmodule
`default_nettype wire

// [logic/reg_store.sv]
`timescale 1ns/10ps
`default_nettype none
module reg_store #(
   parameter int Depth = codec_ctrl_pkg::REG_COUNT,
   parameter int AddrW = 6,
   parameter int TapAddr = 0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wrEn,
   input wire logic [AddrW-1:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic [AddrW-1:0] rdAddr,
   output logic [7:0] rdData,
   output logic [7:0] tapData
);
   logic [7:0] mem_q [Depth];

   if (Depth < 1 || Depth > (1 << AddrW) || TapAddr >= Depth) begin : g_check
      $error("reg_store depth, address width or tap out of range");
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < Depth; i++) begin
            mem_q[i] <= codec_ctrl_pkg::REG_RESET;
         end
      end else if (wrEn && int'(wrAddr) < Depth) begin
         mem_q[wrAddr] <= wrData;
      end
   end

   // Registered read port; one cycle from address to data
   always_ff @(posedge clk) begin
      if (srst) begin
         rdData <= codec_ctrl_pkg::REG_RESET;
      end else if (int'(rdAddr) < Depth) begin
         rdData <= mem_q[rdAddr];
      end else begin
         rdData <= codec_ctrl_pkg::REG_RESET;
      end
   end

   // Fixed tap so the port logic can see one control field without a read cycle
   assign tapData = mem_q[TapAddr];
endmodule
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module host_model (
   output logic scl,
   output logic sda,
   output logic csN,
   input wire logic sdaW,
   input wire logic gp2,
   input wire logic gp2OeN
);
   // Quarter of the 160 ns link period; all moves stay off the sampling edge
   localparam int Q = 40;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      csN = 1'b1;
   end
   task automatic start();
      sda = 1'b1;
      #Q scl = 1'b1;
      #(2*Q) sda = 1'b0;
      #(2*Q) scl = 1'b0;
      #Q;
   endtask
   task automatic stop();
      sda = 1'b0;
      #Q scl = 1'b1;
      #(2*Q) sda = 1'b1;
      #(2*Q);
   endtask
   task automatic clkBit(input logic d, output logic s);
      sda = d;
      #Q scl = 1'b1;
      #Q s = sdaW;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clkBit(tx[i], s);
         rx = {rx[6:0], s};
      end
      clkBit(ackIn, ack);
   endtask
   task automatic frame(input logic [15:0] w, output logic [7:0] rb);
      scl = 1'b0;
      #(2*Q) csN = 1'b0;
      #(2*Q);
      for (int i = 15; i >= 0; i--) begin
         sda = w[i];
         #(2*Q) scl = 1'b1;
         // Undriven pin reads inverted so a stale level never passes
         if (i < 8) rb = {rb[6:0], gp2OeN ? ~gp2 : gp2};
         #(2*Q) scl = 1'b0;
      end
      #(2*Q) csN = 1'b1;
      sda = ~sda;
      #(4*Q);
   endtask
endmodule
`default_nettype wire

// [tb/codec_ctrl_port_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module codec_ctrl_port_monitor #(
   parameter int RegCount = 38
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic serialClkPin,
   input wire logic serialDataIn,
   input wire logic serialDataOeN,
   input wire logic ifaceSelStrap,
   input wire logic chipSelectN,
   input wire logic generalPinTwoOut,
   input wire logic generalPinTwoOeN,
   input wire logic regWritePulse,
   input wire logic [7:0] regWriteIndex,
   input wire logic busBusy,
   input wire logic threeWireMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence startSeen;
      !threeWireMode && serialClkPin && $fell(serialDataIn);
   endsequence
   sequence stopSeen;
      !threeWireMode && serialClkPin && $rose(serialDataIn);
   endsequence
   busy_on_start_a: assert property (startSeen |-> ##[1:6] busBusy)
      else $error("busy missing after start");
   busy_off_stop_a: assert property (stopSeen |-> ##[1:6] !busBusy)
      else $error("busy stuck after stop");
   // Pins pass two sync flops, so the clock level three edges back is the true one
   sda_steady_a: assert property (!threeWireMode && $changed(serialDataOeN)
      |-> !$past(serialClkPin, 3))
      else $error("data line moved with clock high");
   ack_commit_a: assert property (!threeWireMode && regWritePulse
      |-> $past(serialClkPin, 3) && !serialDataOeN)
      else $error("write outside final acknowledge");
   quiet_3w_a: assert property (threeWireMode |-> serialDataOeN && !busBusy)
      else $error("two-wire logic active in three-wire mode");
   pin_off_2w_a: assert property (!threeWireMode |-> generalPinTwoOeN)
      else $error("general pin driven in two-wire mode");
   rb_steady_a: assert property (threeWireMode && $changed(generalPinTwoOut)
      |-> !$past(serialClkPin, 3))
      else $error("read-back bit moved with clock high");
   cs_commit_a: assert property (threeWireMode && regWritePulse
      |-> chipSelectN && $past(chipSelectN, 2))
      else $error("write before deselect");
   mode_latch_a: assert property ($fell(srst) |-> threeWireMode == $past(ifaceSelStrap, 4))
      else $error("mode does not follow strap");
   mode_hold_a: assert property (!$past(srst) |-> $stable(threeWireMode))
      else $error("mode changed outside reset");
   index_range_a: assert property (regWritePulse |-> regWriteIndex < RegCount)
      else $error("write to missing register");
endmodule
bind codec_ctrl_port codec_ctrl_port_monitor #(.RegCount(RegCount)) i_mon (
   .clk(clk),
   .srst(srst),
   .serialClkPin(serialClkPin),
   .serialDataIn(serialDataIn),
   .serialDataOeN(serialDataOeN),
   .ifaceSelStrap(ifaceSelStrap),
   .chipSelectN(chipSelectN),
   .generalPinTwoOut(generalPinTwoOut),
   .generalPinTwoOeN(generalPinTwoOeN),
   .regWritePulse(regWritePulse),
   .regWriteIndex(regWriteIndex),
   .busBusy(busBusy),
   .threeWireMode(threeWireMode)
);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic strap = 1'b0;
   logic scl, sdaM, csN, sdaOeN, sdaOut, gp2, gp2OeN, pulse, busy, mode, ack;
   logic [7:0] wIdx, wVal, lastIdx, lastVal, rx;
   int mismatches = 0;
   int compares = 0;
   int pulses = 0;
   int cyc = 0;
   // Open-drain wire with pull-up
   wire logic sdaW = sdaM & (sdaOeN | sdaOut);
   codec_ctrl_port i_codec_ctrl_port (.clk(clk), .srst(srst), .serialClkPin(scl),
      .serialDataIn(sdaW), .serialDataOut(sdaOut), .serialDataOeN(sdaOeN),
      .ifaceSelStrap(strap), .chipSelectN(csN), .generalPinTwoOut(gp2),
      .generalPinTwoOeN(gp2OeN), .regWritePulse(pulse), .regWriteIndex(wIdx),
      .regWriteValue(wVal), .busBusy(busy), .threeWireMode(mode));
   host_model i_host_model (.scl(scl), .sda(sdaM), .csN(csN), .sdaW(sdaW), .gp2(gp2),
      .gp2OeN(gp2OeN));
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (pulse === 1'b1) begin
         pulses++;
         lastIdx = wIdx;
         lastVal = wVal;
      end
      if (cyc == 8000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic expAck);
      i_host_model.xfer(b, 1'b1, rx, ack);
      check({7'h00, ack}, {7'h00, expAck});
   endtask
   task automatic t_write();
      i_host_model.start();
      send(8'h34, 1'b0);
      send(8'h05, 1'b0);
      send(8'hA5, 1'b0);
      check(pulses[7:0], 8'h01);
      check(lastIdx, 8'h05);
      check(lastVal, 8'hA5);
      check({7'h00, busy}, 8'h01);
      i_host_model.stop();
      check({7'h00, busy}, 8'h00);
   endtask
   task automatic t_badaddr();
      i_host_model.start();
      send(8'h36, 1'b1);
      send(8'h05, 1'b1);
      i_host_model.stop();
      check(pulses[7:0], 8'h01);
   endtask
   task automatic t_read();
      i_host_model.start();
      send(8'h34, 1'b0);
      send(8'h05, 1'b0);
      i_host_model.start();
      send(8'h35, 1'b0);
      i_host_model.xfer(8'hFF, 1'b1, rx, ack);
      check(rx, 8'hA5);
      i_host_model.stop();
      check({7'h00, busy}, 8'h00);
   endtask
   task automatic t_burst();
      i_host_model.start();
      send(8'h34, 1'b0);
      send(8'h24, 1'b0);
      send(8'h11, 1'b0);
      send(8'h22, 1'b0);
      send(8'h33, 1'b0);
      check(pulses[7:0], 8'h03);
      check(lastIdx, 8'h25);
      check(lastVal, 8'h22);
      i_host_model.start();
      send(8'h34, 1'b0);
      send(8'h24, 1'b0);
      i_host_model.start();
      send(8'h35, 1'b0);
      i_host_model.xfer(8'hFF, 1'b0, rx, ack);
      check(rx, 8'h11);
      i_host_model.xfer(8'hFF, 1'b0, rx, ack);
      check(rx, 8'h22);
      i_host_model.xfer(8'hFF, 1'b1, rx, ack);
      check(rx, 8'h00);
      i_host_model.stop();
      check({7'h00, busy}, 8'h00);
   endtask
   task automatic t_spi();
      @(posedge clk);
      #1 srst = 1'b1;
      strap = 1'b1;
      repeat (10) @(posedge clk);
      #1 srst = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      check({7'h00, mode}, 8'h01);
      check({7'h00, gp2OeN}, 8'h01);
      i_host_model.frame({codec_ctrl_pkg::PIN_FUNC_REG, 8'h08}, rx);
      check(lastIdx, 8'h1A);
      check({7'h00, gp2OeN}, 8'h00);
      i_host_model.frame(16'h053C, rx);
      check(lastVal, 8'h3C);
      i_host_model.frame(16'h8500, rx);
      check(rx, 8'h3C);
      i_host_model.frame(16'h9A00, rx);
      check(rx, 8'h08);
      check(pulses[7:0], 8'h05);
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 srst = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      t_write();
      t_badaddr();
      t_read();
      t_burst();
      t_spi();
      wrap_up();
   end
endmodule
`default_nettype wire
